// File: core/dcc_crc_append.v
// crc / checksum append control for a dma data path with avalon-mm registers
// Summary of operation
// - append mode: data to crc, not destination
// - append: block end writes crc to destination start
// - no append: data to crc and destination
// - kind bit: one checksum, zero lfsr
// - channel field picks engine's channel 0-7
// - write byte order set blocks append bit
// - bits four and three read zero
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defs.vh"
module dcc_crc_append #(
    parameter NCH   = 8,
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rst_n_in,
    // avalon-mm slave
    input  wire [3:0]       avs_address_in,
    input  wire             avs_read_in,
    input  wire             avs_write_in,
    input  wire [31:0]      avs_writedata_in,
    output reg  [31:0]      avs_readdata_out,
    output reg              avs_waitrequest_out,
    // source stream from the dma channels
    input  wire             src_valid_in,
    input  wire [2:0]       src_channel_in,
    input  wire [WIDTH-1:0] src_data_in,
    input  wire             src_last_in,
    output wire             src_ready_out,
    input  wire [31:0]      channel_destination_start_in,
    // destination write stream
    output reg              dst_valid_out,
    output reg  [2:0]       dst_channel_out,
    output reg  [WIDTH-1:0] dst_data_out,
    output reg  [31:0]      dst_addr_out,
    output reg              dst_is_crc_out,
    input  wire             dst_ready_in
);
    localparam S_IDLE = 3'b001;
    localparam S_ACK  = 3'b010;
    localparam S_DONE = 3'b100;

    reg  [31:0]      ctrl_reg;
    reg  [31:0]      poly_reg;
    reg  [31:0]      seed_reg;
    reg  [31:0]      crc_reg;
    reg  [31:0]      crc_next;
    reg  [2:0]       bus_state_reg;
    reg              crc_pend_reg;
    reg  [2:0]       crc_pend_ch_reg;
    reg  [31:0]      crc_pend_addr_reg;
    reg  [31:0]      crc_acc_next;
    reg              crc_pend_next;
    reg  [2:0]       crc_pend_ch_next;
    reg  [31:0]      crc_pend_addr_next;
    reg              dst_valid_next;
    reg              dst_is_crc_next;
    reg  [2:0]       dst_channel_next;
    reg  [WIDTH-1:0] dst_data_next;
    reg  [31:0]      dst_addr_next;
    reg  [31:0]      ctrl_next;
    reg  [31:0]      poly_next;
    reg  [31:0]      seed_next;
    reg  [31:0]      rd_next;
    reg  [2:0]       bus_state_next;
    reg              wait_next;

    wire             append_sel;
    wire             kind_sel;
    wire [2:0]       ch_sel;
    wire             wbo_sel;
    wire             fifo_valid;
    wire             fifo_ready;
    wire [WIDTH+3:0] fifo_data;
    wire             f_last;
    wire [2:0]       f_ch;
    wire [WIDTH-1:0] f_word;
    wire             f_on_crc;
    wire             f_pass;
    wire             out_free;
    wire [31:0]      ctrl_wr;
    wire [16:0]      sum_lo;
    wire [16:0]      sum_hi;
    wire [16:0]      sum_all;
    wire [NCH-1:0]   ch_hit;
    wire             wr_land;
    wire             rd_take;
    integer          b;

    assign append_sel = ctrl_reg[`DCC_APPEND_BIT];
    assign kind_sel   = ctrl_reg[`DCC_KIND_BIT];
    assign ch_sel     = ctrl_reg[`DCC_CH_MSB:`DCC_CH_LSB];
    assign wbo_sel    = ctrl_reg[`DCC_WBO_BIT];

    dcc_fifo #(
        .WIDTH (WIDTH + 4),
        .DEPTH (`DCC_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (src_valid_in),
        .in_ready_out  (src_ready_out),
        .in_data_in    ({src_last_in, src_channel_in, src_data_in}),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_ready),
        .out_data_out  (fifo_data)
    );

    assign f_word = fifo_data[WIDTH-1:0];
    assign f_ch   = fifo_data[WIDTH+2:WIDTH];
    assign f_last = fifo_data[WIDTH+3];

    // one-hot channel match
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_hit
            localparam [2:0] CH_NUM = g;
            assign ch_hit[g] = (ch_sel == CH_NUM);
        end
    endgenerate

    assign f_on_crc = ch_hit[f_ch];
    assign f_pass   = ~(f_on_crc & append_sel);
    assign out_free = ~dst_valid_out | dst_ready_in;
    // stall while the appended crc word waits to go out
    assign fifo_ready = out_free & ~crc_pend_reg;

    // ones-complement 16-bit sum for the checksum kind
    assign sum_lo  = {1'b0, crc_reg[15:0]} + {1'b0, f_word[15:0]};
    assign sum_hi  = {1'b0, sum_lo[15:0]} + {16'h0000, sum_lo[16]};
    assign sum_all = {1'b0, sum_hi[15:0]} + {1'b0, f_word[31:16]};

    always @* begin
        crc_next = crc_reg;
        if (kind_sel) begin
            crc_next = {16'h0000, sum_all[15:0] + {15'h0000, sum_all[16]}};
        end else begin
            crc_next = crc_reg ^ f_word[31:0];
            for (b = 0; b < 32; b = b + 1) begin
                crc_next = crc_next[31] ? ((crc_next << 1) ^ poly_reg) : (crc_next << 1);
            end
        end
    end

    // byte order: swap lanes when set
    function [WIDTH-1:0] dcc_order;
        input [WIDTH-1:0] d;
        input             swap;
        begin
            dcc_order = swap ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
        end
    endfunction

    // data path next values
    always @* begin
        crc_acc_next       = crc_reg;
        crc_pend_next      = crc_pend_reg;
        crc_pend_ch_next   = crc_pend_ch_reg;
        crc_pend_addr_next = crc_pend_addr_reg;
        dst_valid_next     = dst_valid_out;
        dst_is_crc_next    = dst_is_crc_out;
        dst_channel_next   = dst_channel_out;
        dst_data_next      = dst_data_out;
        dst_addr_next      = dst_addr_out;
        if (out_free) begin
            dst_valid_next  = 1'b0;
            dst_is_crc_next = 1'b0;
        end
        if (crc_pend_reg && out_free) begin
            dst_valid_next   = 1'b1;
            dst_is_crc_next  = 1'b1;
            dst_channel_next = crc_pend_ch_reg;
            dst_addr_next    = crc_pend_addr_reg;
            dst_data_next    = crc_reg[WIDTH-1:0];
            crc_pend_next    = 1'b0;
        end else if (fifo_valid && fifo_ready) begin
            if (f_on_crc) begin
                crc_acc_next = crc_next;
            end
            if (f_pass) begin
                dst_valid_next   = 1'b1;
                dst_channel_next = f_ch;
                dst_data_next    = dcc_order(f_word, wbo_sel);
            end
            if (f_on_crc && append_sel && f_last) begin
                crc_pend_next      = 1'b1;
                crc_pend_ch_next   = f_ch;
                crc_pend_addr_next = channel_destination_start_in;
            end
        end
        // a seed write restarts the running value
        if (wr_land && avs_address_in == `DCC_SEED_ADDR) begin
            crc_acc_next = avs_writedata_in;
        end
    end

    // data path registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_reg           <= `DCC_SEED_RESET;
            crc_pend_reg      <= 1'b0;
            crc_pend_ch_reg   <= 3'b000;
            crc_pend_addr_reg <= 32'h0000_0000;
            dst_valid_out     <= 1'b0;
            dst_channel_out   <= 3'b000;
            dst_data_out      <= {WIDTH{1'b0}};
            dst_addr_out      <= 32'h0000_0000;
            dst_is_crc_out    <= 1'b0;
        end else begin
            crc_reg           <= crc_acc_next;
            crc_pend_reg      <= crc_pend_next;
            crc_pend_ch_reg   <= crc_pend_ch_next;
            crc_pend_addr_reg <= crc_pend_addr_next;
            dst_valid_out     <= dst_valid_next;
            dst_channel_out   <= dst_channel_next;
            dst_data_out      <= dst_data_next;
            dst_addr_out      <= dst_addr_next;
            dst_is_crc_out    <= dst_is_crc_next;
        end
    end

    // control write value with unimplemented bits dropped
    assign ctrl_wr = (avs_writedata_in & `DCC_CTRL_MASK)
                     & ~({31'h0000_0000, avs_writedata_in[`DCC_WBO_BIT]} << `DCC_APPEND_BIT);

    // a write lands on the edge that sees waitrequest low
    assign wr_land = avs_write_in & (bus_state_reg == S_ACK);
    assign rd_take = avs_read_in & ~avs_write_in & (bus_state_reg == S_IDLE);

    // readback value, captured when a read is taken
    always @* begin
        rd_next = 32'h0000_0000;
        case (avs_address_in)
            `DCC_CTRL_ADDR:   rd_next = ctrl_reg & `DCC_CTRL_MASK;
            `DCC_POLY_ADDR:   rd_next = poly_reg;
            `DCC_SEED_ADDR:   rd_next = seed_reg;
            `DCC_RESULT_ADDR: rd_next = crc_reg;
            `DCC_STATUS_ADDR: rd_next = {30'h0000_0000, crc_pend_reg, fifo_valid};
            default:          rd_next = 32'h0000_0000;
        endcase
    end

    // register file next values
    always @* begin
        ctrl_next = ctrl_reg;
        poly_next = poly_reg;
        seed_next = seed_reg;
        if (wr_land) begin
            case (avs_address_in)
                `DCC_CTRL_ADDR: ctrl_next = ctrl_wr;
                `DCC_POLY_ADDR: poly_next = avs_writedata_in;
                `DCC_SEED_ADDR: seed_next = avs_writedata_in;
                default: ;
            endcase
        end
    end

    // bus sequencer: take, answer, one idle cycle
    always @* begin
        bus_state_next = bus_state_reg;
        wait_next      = 1'b1;
        case (bus_state_reg)
            S_IDLE: begin
                if (avs_write_in | avs_read_in) begin
                    wait_next      = 1'b0;
                    bus_state_next = S_ACK;
                end
            end
            S_ACK: begin
                bus_state_next = S_DONE;
            end
            S_DONE: begin
                bus_state_next = S_IDLE;
            end
            default: begin
                bus_state_next = S_IDLE;
            end
        endcase
    end

    // avalon slave registers
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_state_reg       <= S_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
            ctrl_reg            <= `DCC_CTRL_RESET;
            poly_reg            <= `DCC_POLY_RESET;
            seed_reg            <= `DCC_SEED_RESET;
        end else begin
            bus_state_reg       <= bus_state_next;
            avs_waitrequest_out <= wait_next;
            ctrl_reg            <= ctrl_next;
            poly_reg            <= poly_next;
            seed_reg            <= seed_next;
            if (rd_take) begin
                avs_readdata_out <= rd_next;
            end
        end
    end
endmodule
`default_nettype wire

// File: pkg/dcc_defs.vh
// register offsets, field positions, reset values and counts of the crc append control
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH
`define DCC_CTRL_ADDR      4'h0
`define DCC_POLY_ADDR      4'h1
`define DCC_SEED_ADDR      4'h2
`define DCC_RESULT_ADDR    4'h3
`define DCC_STATUS_ADDR    4'h4
`define DCC_CH_LSB         0
`define DCC_CH_MSB         2
`define DCC_KIND_BIT       5
`define DCC_APPEND_BIT     6
`define DCC_WBO_BIT        7
`define DCC_CTRL_MASK      32'h0000_00E7
`define DCC_CTRL_RESET     32'h0000_0000
`define DCC_POLY_RESET     32'h04C1_1DB7
`define DCC_SEED_RESET     32'h0000_0000
`define DCC_FIFO_DEPTH     16
`endif

// File: core/dcc_fifo.v
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dcc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rst_n_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;
    wire [AW:0]     count_next;
    reg             ready_reg;
    integer         i;

    // ready is registered so the fill side sees a flip-flop
    assign in_ready_out  = ready_reg;
    assign count_next    = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out  = mem_reg[rd_ptr_reg];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            ready_reg  <= 1'b1;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data_in;
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            ready_reg <= (count_next != DEPTH[AW:0]);
        end
    end
endmodule
`default_nettype wire

// File: sim/dcc_crc_append_sva.sv
// port assertions for the crc append control
`timescale 1ns/10ps
`default_nettype none
module dcc_crc_append_sva #(
    parameter WIDTH = 32
) (
    input wire             clk_in,
    input wire             rst_n_in,
    input wire [3:0]       avs_address_in,
    input wire             avs_read_in,
    input wire             avs_write_in,
    input wire [31:0]      avs_writedata_in,
    input wire [31:0]      avs_readdata_out,
    input wire             avs_waitrequest_out,
    input wire             src_valid_in,
    input wire [2:0]       src_channel_in,
    input wire             src_last_in,
    input wire             src_ready_out,
    input wire             dst_valid_out,
    input wire [2:0]       dst_channel_out,
    input wire [WIDTH-1:0] dst_data_out,
    input wire             dst_is_crc_out,
    input wire             dst_ready_in
);
    reg  [7:0] cfg_reg;
    wire       rd_ctl = avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0;
    wire       sel    = cfg_reg[6] && src_channel_in == cfg_reg[2:0];
    wire       crc_w  = dst_valid_out && dst_is_crc_out;
    // control mirror, write byte order blocks append
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            cfg_reg <= 8'h00;
        else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0)
            cfg_reg <= avs_writedata_in[7:0] & (avs_writedata_in[7] ? 8'hA7 : 8'hE7);
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_sel_last;
        src_valid_in && src_ready_out && src_last_in && sel;
    endsequence
    sequence s_crc_out;
        crc_w && dst_ready_in;
    endsequence
    a_bus_answer: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("bus request not answered");
    a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_ctrl_zero_bits: assert property (rd_ctl |-> avs_readdata_out[31:8] == 0 && avs_readdata_out[4:3] == 0)
        else $error("control unused bits not zero");
    a_wbo_no_append: assert property (rd_ctl |-> !(avs_readdata_out[7] && avs_readdata_out[6]))
        else $error("append set with byte order");
    a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in > 4'h4 |-> avs_readdata_out == 0)
        else $error("unmapped read not zero");
    a_dst_hold: assert property (dst_valid_out && !dst_ready_in |=> dst_valid_out && $stable(dst_data_out))
        else $error("destination word dropped");
    a_append_no_data: assert property (dst_valid_out && !dst_is_crc_out && cfg_reg[6] |-> dst_channel_out != cfg_reg[2:0])
        else $error("append data reached destination");
    a_crc_channel: assert property (crc_w |-> dst_channel_out == cfg_reg[2:0])
        else $error("crc word on wrong channel");
    a_crc_only_append: assert property (crc_w |-> cfg_reg[6])
        else $error("crc word without append");
    a_append_end: assert property (s_sel_last |-> ##[2:100] s_crc_out)
        else $error("no crc word after block end");
    a_pass_word: assert property (src_valid_in && src_ready_out && !sel |-> ##[2:100] dst_valid_out && !dst_is_crc_out)
        else $error("passed word missing");
endmodule
bind dcc_crc_append dcc_crc_append_sva #(.WIDTH(WIDTH)) u_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .src_valid_in(src_valid_in), .src_channel_in(src_channel_in),
    .src_last_in(src_last_in), .src_ready_out(src_ready_out), .dst_valid_out(dst_valid_out),
    .dst_channel_out(dst_channel_out), .dst_data_out(dst_data_out), .dst_is_crc_out(dst_is_crc_out),
    .dst_ready_in(dst_ready_in)
);
`default_nettype wire

// File: sim/dcc_dma_sink.sv
// destination side model: takes destination writes, stalls on command
`timescale 1ns/10ps
`default_nettype none
module dcc_dma_sink (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        hold_in,
    input  wire        slow_in,
    input  wire        valid_in,
    input  wire [2:0]  ch_in,
    input  wire [31:0] data_in,
    input  wire [31:0] addr_in,
    input  wire        crc_in,
    output wire        ready_out,
    output reg  [15:0] cnt_out,
    output reg  [2:0]  ch_out,
    output reg  [31:0] data_out,
    output reg  [31:0] addr_out,
    output reg         crc_out
);
    reg tog_reg;
    // slow mode accepts every other cycle
    assign ready_out = !hold_in && (!slow_in || tog_reg);
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tog_reg <= 1'b0;
            cnt_out <= 16'h0000;
        end else begin
            tog_reg <= !tog_reg;
            if (valid_in && ready_out) begin
                cnt_out  <= cnt_out + 16'h0001;
                ch_out   <= ch_in;
                data_out <= data_in;
                addr_out <= addr_in;
                crc_out  <= crc_in;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_dcc_crc_append.sv
// self-checking bench of the crc append control
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defs.vh"
module tb_dcc_crc_append;
    reg         clk_in, rst_n_in, avs_read_in, avs_write_in, src_valid_in, src_last_in, hold, slow;
    reg  [3:0]  avs_address_in;
    reg  [2:0]  src_channel_in;
    reg  [31:0] avs_writedata_in, src_data_in, rd, e, d, dsa;
    wire [31:0] avs_readdata_out, dst_data_out, dst_addr_out, k_data, k_addr;
    wire [2:0]  dst_channel_out, k_ch;
    wire        avs_waitrequest_out, src_ready_out, dst_valid_out, dst_is_crc_out, dst_ready_in, k_crc;
    wire [15:0] k_cnt;
    integer     n_fail, checks, i, t, n0;
    dcc_crc_append DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .src_valid_in(src_valid_in), .src_channel_in(src_channel_in), .src_data_in(src_data_in),
        .src_last_in(src_last_in), .src_ready_out(src_ready_out), .channel_destination_start_in(dsa),
        .dst_valid_out(dst_valid_out), .dst_channel_out(dst_channel_out), .dst_data_out(dst_data_out),
        .dst_addr_out(dst_addr_out), .dst_is_crc_out(dst_is_crc_out), .dst_ready_in(dst_ready_in));
    dcc_dma_sink u_sink (.clk_in(clk_in), .rst_n_in(rst_n_in), .hold_in(hold), .slow_in(slow),
        .valid_in(dst_valid_out), .ch_in(dst_channel_out), .data_in(dst_data_out), .addr_in(dst_addr_out),
        .crc_in(dst_is_crc_out), .ready_out(dst_ready_in), .cnt_out(k_cnt), .ch_out(k_ch),
        .data_out(k_data), .addr_out(k_addr), .crc_out(k_crc));
    function [31:0] lfsr(input [31:0] c, input [31:0] x);
        integer j;
        begin
            for (j = 31; j >= 0; j = j - 1)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ x[j]) ? 32'h04C1_1DB7 : 32'h0000_0000);
            lfsr = c;
        end
    endfunction
    function [31:0] csum(input [31:0] c, input [31:0] x);
        reg [17:0] s;
        begin
            s = c[15:0] + x[31:16] + x[15:0];
            s = s[15:0] + s[17:16];
            s = s[15:0] + s[17:16];
            csum = {16'h0000, s[15:0]};
        end
    endfunction
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            checks = checks + 1;
            if (got !== ex) begin
                n_fail = n_fail + 1;
                $display("wrong value %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] wd);
        begin
            avs_write_in <= w;
            avs_read_in <= !w;
            avs_address_in <= a;
            avs_writedata_in <= wd;
            @(posedge clk_in);
            while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
            rd = avs_readdata_out;
            avs_write_in <= 1'b0;
            avs_read_in <= 1'b0;
            @(posedge clk_in);
        end
    endtask
    task snd(input [2:0] ch, input [31:0] x, input l);
        begin
            src_valid_in <= 1'b1;
            src_channel_in <= ch;
            src_data_in <= x;
            src_last_in <= l;
            @(posedge clk_in);
            while (src_ready_out !== 1'b1) @(posedge clk_in);
        end
    endtask
    task wcnt(input integer n);
        begin
            src_valid_in <= 1'b0;
            repeat (200) if (k_cnt < n) @(posedge clk_in);
            repeat (10) @(posedge clk_in);
            chk("word count", n, k_cnt);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        summarize;
    end
    initial begin
        {rst_n_in, avs_read_in, avs_write_in, src_valid_in, src_last_in, hold, slow} = 7'h00;
        {avs_address_in, src_channel_in, avs_writedata_in, src_data_in} = 0;
        dsa = 32'h0000_8000;
        n_fail = 0;
        checks = 0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        bus(0, 4'h0, 0);
        chk("ctrl reset", 0, rd);
        bus(1, 4'h0, 32'hFFFF_FFFF);
        bus(0, 4'h0, 0);
        chk("ctrl byte order", 32'h0000_00A7, rd);
        bus(1, 4'h0, 32'h0000_005F);
        bus(0, 4'h0, 0);
        chk("ctrl append", 32'h0000_0047, rd);
        bus(0, 4'hF, 0);
        chk("unmapped", 0, rd);
        $display("register test done");
        bus(1, 4'h0, 32'h0000_0083);
        n0 = k_cnt;
        snd(3'd3, 32'h1122_3344, 1'b1);
        wcnt(n0 + 1);
        chk("swapped word", 32'h4433_2211, k_data);
        $display("pass test done");
        for (t = 0; t < 2; t = t + 1) begin
            bus(1, 4'h2, 0);
            bus(1, 4'h0, {25'h0, 1'b1, t[0], 5'h02});
            n0 = k_cnt;
            slow <= 1'b1;
            dsa <= 32'h0000_8000 + 32'h0000_0100 * t;
            e = 0;
            for (i = 0; i < 4; i = i + 1) begin
                d = 32'hF123_8765 ^ i;
                snd(3'd5, ~d, 1'b0);
                snd(3'd2, d, i == 3);
                e = t ? csum(e, d) : lfsr(e, d);
            end
            wcnt(n0 + 5);
            slow <= 1'b0;
            chk("crc value", e, k_data);
            chk("crc flag", 1, k_crc);
            chk("crc address", 32'h0000_8000 + 32'h0000_0100 * t, k_addr);
            chk("crc channel", 2, k_ch);
            $display("append test done");
        end
        bus(1, 4'h0, 0);
        hold <= 1'b1;
        n0 = k_cnt;
        i = 0;
        src_valid_in <= 1'b1;
        src_channel_in <= 3'd1;
        src_last_in <= 1'b0;
        src_data_in <= 0;
        repeat (30) begin
            @(posedge clk_in);
            if (src_ready_out === 1'b1)
                i = i + 1;
            src_data_in <= i;
        end
        hold <= 1'b0;
        chk("fifo refuses", `DCC_FIFO_DEPTH + 1, i);
        wcnt(n0 + i);
        chk("last drained", i - 1, k_data);
        bus(0, 4'h4, 0);
        chk("status idle", 0, rd & 32'h0000_0003);
        $display("fifo test done");
        summarize;
    end
endmodule
`default_nettype wire
